/* verilog/srf_pkg.sv */
// package: refresh command encodings, timing counts and shared helpers
package srf_pkg;
   localparam int CLK_NS = 40;
   localparam int NUM_BANKS = 8;
   localparam int BANK_W = 3;
   localparam int CA_W = 10;
   localparam int TMR_W = 8;
   // -------------------------------------------------------------
   // command/address field positions and codes
   // -------------------------------------------------------------
   localparam int AB_BIT = 3;
   localparam int PRE_ALL_BIT = 4;
   localparam int BANK_LSB = 7;
   localparam int MR_LSB = 4;
   localparam logic [2:0] OP_REF = 3'h4;
   localparam logic [1:0] OP_ACT = 2'h2;
   localparam logic [3:0] OP_PRE = 4'hb;
   localparam logic [3:0] OP_MRW = 4'h0;
   localparam logic [5:0] MR_RESET = 6'h3f;
   // -------------------------------------------------------------
   // times in ns and derived cycle counts
   // -------------------------------------------------------------
   localparam int RFCAB_NS = 130;
   localparam int RFCPB_NS = 60;
   localparam int RRD_NS = 10;
   localparam int RP_NS = 18;
   localparam int XSR_NS = 140;
   localparam int REFI_NS = 7800;
   localparam int BURST_REFS = 8;
   localparam int BURST_NS = 4 * 8 * RFCAB_NS;
   localparam logic [TMR_W-1:0] RFCAB_CYC =
      TMR_W'((RFCAB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] RFCPB_CYC =
      TMR_W'((RFCPB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] RRD_CYC =
      TMR_W'((RRD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] RP_CYC =
      TMR_W'((RP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] XSR_CYC =
      TMR_W'((XSR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] REFI_CYC = TMR_W'(REFI_NS / CLK_NS);
   localparam logic [TMR_W-1:0] REFI_PB_CYC =
      TMR_W'(REFI_NS / NUM_BANKS / CLK_NS);
   localparam logic [TMR_W-1:0] BURST_GAP_CYC =
      TMR_W'((BURST_NS + BURST_REFS * CLK_NS - 1) / (BURST_REFS * CLK_NS));
   typedef enum logic [2:0] {
      CMD_NOP, CMD_PB_REF, CMD_AB_REF, CMD_ACT,
      CMD_PRE, CMD_PRE_ALL, CMD_RESET, CMD_SR_ENTER
   } srf_cmd_t;
   typedef logic [TMR_W-1:0] srf_tmr_t;
   function automatic srf_tmr_t tick(srf_tmr_t t);
      return (t == '0) ? t : t - srf_tmr_t'(1);
   endfunction : tick
endpackage : srf_pkg

/* verilog/srf_if.sv */
// interface: command/address bus between controller and memory
`timescale 1ns/1ps
interface srf_if;
   logic cke;
   logic cs_n;
   logic [srf_pkg::CA_W-1:0] ca;
   modport ctrl (output cke, output cs_n, output ca);
   modport dev (input cke, input cs_n, input ca);
endinterface : srf_if

/* verilog/srf_cmd_decode.sv */
// module: combinational decode of one command/address word
`timescale 1ns/1ps
module srf_cmd_decode (
   // command bus
   input wire logic cs_n,
   input wire logic cke,
   input wire logic [srf_pkg::CA_W-1:0] ca,
   // decoded command
   output srf_pkg::srf_cmd_t cmd
);
   always_comb begin
      cmd = srf_pkg::CMD_NOP;
      if (!cs_n) begin
         if (ca[2:0] == srf_pkg::OP_REF) begin
            if (!cke)
               cmd = srf_pkg::CMD_SR_ENTER;
            else if (ca[srf_pkg::AB_BIT])
               cmd = srf_pkg::CMD_AB_REF;
            else
               cmd = srf_pkg::CMD_PB_REF;
         end else if (ca[1:0] == srf_pkg::OP_ACT) begin
            cmd = srf_pkg::CMD_ACT;
         end else if (ca[3:0] == srf_pkg::OP_PRE) begin
            cmd = ca[srf_pkg::PRE_ALL_BIT] ? srf_pkg::CMD_PRE_ALL
                                           : srf_pkg::CMD_PRE;
         end else if (ca[3:0] == srf_pkg::OP_MRW &&
                      ca[srf_pkg::MR_LSB +: 6] == srf_pkg::MR_RESET) begin
            cmd = srf_pkg::CMD_RESET;
         end
      end
   end
endmodule : srf_cmd_decode

/* verilog/srf_device.sv */
// module: memory-side refresh logic with per-bank pointer
`timescale 1ns/1ps
module srf_device #(
   parameter int NUM_BANKS = srf_pkg::NUM_BANKS
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // command bus
   srf_if.dev BUS,
   // status
   output logic [srf_pkg::BANK_W-1:0] REF_PTR,
   output logic REF_BANK_PULSE,
   output logic REF_ALL_PULSE,
   output logic [7:0] BANK_ACTIVE,
   output logic [7:0] BANK_BUSY,
   output logic IN_SELF_REFRESH,
   output logic CMD_ERROR
);
   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   srf_pkg::srf_cmd_t cmd;
   logic [srf_pkg::BANK_W-1:0] bank;
   srf_cmd_decode u_dec (
      .cs_n(BUS.cs_n),
      .cke(BUS.cke),
      .ca(BUS.ca),
      .cmd(cmd)
   );
   // single-bank precharge and per-bank pointer share this numbering
   assign bank = BUS.ca[srf_pkg::BANK_LSB +: srf_pkg::BANK_W];
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [srf_pkg::BANK_W-1:0] ptr, next_ptr;
   logic [7:0] active, next_active;
   srf_pkg::srf_tmr_t busy [8];
   srf_pkg::srf_tmr_t next_busy [8];
   logic sref, next_sref;
   logic pb_p, next_pb_p, ab_p, next_ab_p, err, next_err;
   logic [7:0] busy_q, next_busy_q;
   logic any_busy;
   always_comb begin
      next_ptr = ptr;
      next_active = active;
      next_sref = sref;
      next_pb_p = 1'b0;
      next_ab_p = 1'b0;
      next_err = 1'b0;
      any_busy = 1'b0;
      for (int i = 0; i < 8; i++) begin
         any_busy = any_busy | (busy[i] != '0);
         next_busy[i] = srf_pkg::tick(busy[i]);
      end
      if (sref) begin
         // only cke matters while self refresh holds the array
         if (BUS.cke) begin
            next_sref = 1'b0;
            next_ptr = '0;
         end
      end else begin
         unique case (cmd)
            srf_pkg::CMD_PB_REF: begin
               if (NUM_BANKS != 8)
                  next_err = 1'b1;
               else if (active[ptr] || busy[ptr] != '0)
                  next_err = 1'b1;
               else begin
                  next_busy[ptr] = srf_pkg::RFCPB_CYC;
                  next_ptr = ptr + 1'b1;
                  next_pb_p = 1'b1;
               end
            end
            srf_pkg::CMD_AB_REF: begin
               if (active != '0 || any_busy)
                  next_err = 1'b1;
               else begin
                  for (int i = 0; i < 8; i++)
                     next_busy[i] = srf_pkg::RFCAB_CYC;
                  next_ptr = '0;
                  next_ab_p = 1'b1;
               end
            end
            srf_pkg::CMD_ACT: begin
               // a bank under refresh cannot be opened
               if (busy[bank] != '0 || active[bank])
                  next_err = 1'b1;
               else
                  next_active[bank] = 1'b1;
            end
            srf_pkg::CMD_PRE: next_active[bank] = 1'b0;
            srf_pkg::CMD_PRE_ALL: next_active = '0;
            srf_pkg::CMD_RESET: begin
               next_ptr = '0;
               next_active = '0;
               for (int i = 0; i < 8; i++)
                  next_busy[i] = '0;
            end
            srf_pkg::CMD_SR_ENTER: begin
               if (active != '0)
                  next_err = 1'b1;
               else
                  next_sref = 1'b1;
            end
            srf_pkg::CMD_NOP: ;
         endcase
      end
      for (int i = 0; i < 8; i++)
         next_busy_q[i] = next_busy[i] != '0;
   end
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ptr <= '0;
         active <= '0;
         sref <= 1'b0;
         pb_p <= 1'b0;
         ab_p <= 1'b0;
         err <= 1'b0;
         busy_q <= '0;
         for (int i = 0; i < 8; i++)
            busy[i] <= '0;
      end else if (CLK_EN) begin
         ptr <= next_ptr;
         active <= next_active;
         sref <= next_sref;
         pb_p <= next_pb_p;
         ab_p <= next_ab_p;
         err <= next_err;
         busy_q <= next_busy_q;
         for (int i = 0; i < 8; i++)
            busy[i] <= next_busy[i];
      end
   end
   assign REF_PTR = ptr;
   assign REF_BANK_PULSE = pb_p;
   assign REF_ALL_PULSE = ab_p;
   assign BANK_ACTIVE = active;
   assign BANK_BUSY = busy_q;
   assign IN_SELF_REFRESH = sref;
   assign CMD_ERROR = err;
endmodule : srf_device

/* verilog/srf_ctrl.sv */
// module: controller-side refresh scheduler and command issuer
`timescale 1ns/1ps
// Operation
// - refresh is cs low, ca 001 pattern
// - ca3 low per-bank, high all-bank
// - per-bank refresh only with eight banks
// - pointer walks banks zero to seven, wraps
// - reset and self-refresh exit clear pointer
// - all-bank refresh also clears pointer
// - pointer numbering matches single-bank precharge
// - controller mirrors pointer, target bank idle
// - per-bank refresh waits its timing gaps
// - refreshing bank inaccessible, others stay usable
// - after per-bank refresh wait its cycle
// - all-bank refresh only with all idle
// - all-bank refresh waits prior refresh, precharge
// - after all-bank refresh wait full cycle
// - open banks forbid all-bank, restrict per-bank
// - meet minimum refresh count each window
// - eight per-bank refreshes replace one all-bank
// - cap all-bank refreshes per burst window
// - self-refresh time may reduce required count
// - regular pattern, one refresh per interval
// - pattern switches keep every window covered
// - self refresh entered and left at burst
// - one refresh round between self refreshes
module srf_ctrl (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // command bus
   srf_if.ctrl BUS,
   // user requests
   input wire logic USE_PER_BANK,
   input wire logic ACT_REQ,
   input wire logic [srf_pkg::BANK_W-1:0] ACT_BANK,
   input wire logic PRE_REQ,
   input wire logic PRE_ALL,
   input wire logic [srf_pkg::BANK_W-1:0] PRE_BANK,
   input wire logic SR_REQ,
   // user status
   output logic ACT_DONE,
   output logic PRE_DONE,
   output logic REF_ISSUED,
   output logic [srf_pkg::BANK_W-1:0] REF_PTR,
   output logic IN_SELF_REFRESH
);
   // -------------------------------------------------------------
   // types and helpers
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_SREF = 2'h1,
      ST_XSR = 2'h3
   } srf_state_t;
   localparam int BW = srf_pkg::BANK_W;
   function automatic logic [srf_pkg::CA_W-1:0] enc(
      input logic [3:0] op, input logic [BW-1:0] b, input logic all);
      enc = '0;
      enc[3:0] = op;
      enc[srf_pkg::PRE_ALL_BIT] = all;
      enc[srf_pkg::BANK_LSB +: BW] = b;
   endfunction : enc
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   srf_state_t st, next_st;
   logic cke, next_cke, cs_n, next_cs_n;
   logic [srf_pkg::CA_W-1:0] ca, next_ca;
   logic [BW-1:0] ptr, next_ptr, pb_bank, next_pb_bank;
   logic [7:0] active, next_active;
   srf_pkg::srf_tmr_t precharge_recovery_time [8];
   srf_pkg::srf_tmr_t next_trp [8];
   srf_pkg::srf_tmr_t t_ab, next_t_ab, t_pb, next_t_pb;
   srf_pkg::srf_tmr_t t_rrd, next_t_rrd, t_gap, next_t_gap;
   srf_pkg::srf_tmr_t t_refi, next_t_refi;
   logic due, next_due, need_ref, next_need_ref;
   logic act_d, next_act_d, pre_d, next_pre_d, ref_d, next_ref_d;
   logic trp_clear, busy_free;
   logic in_sr, next_in_sr;
   always_comb begin
      next_st = st;
      next_cke = 1'b1;
      next_cs_n = 1'b1;
      next_ca = '0;
      next_ptr = ptr;
      next_pb_bank = pb_bank;
      next_active = active;
      next_t_ab = srf_pkg::tick(t_ab);
      next_t_pb = srf_pkg::tick(t_pb);
      next_t_rrd = srf_pkg::tick(t_rrd);
      next_t_gap = srf_pkg::tick(t_gap);
      next_t_refi = srf_pkg::tick(t_refi);
      next_due = due;
      next_need_ref = need_ref;
      next_act_d = 1'b0;
      next_pre_d = 1'b0;
      next_ref_d = 1'b0;
      trp_clear = 1'b1;
      for (int i = 0; i < 8; i++) begin
         next_trp[i] = srf_pkg::tick(precharge_recovery_time[i]);
         trp_clear = trp_clear & (precharge_recovery_time[i] == '0);
      end
      busy_free = t_ab == '0 && t_pb == '0;
      unique case (st)
         ST_RUN: begin
            if (due || (SR_REQ && need_ref)) begin
               if (USE_PER_BANK) begin
                  if (active[ptr]) begin
                     next_cs_n = 1'b0;
                     next_ca = enc(srf_pkg::OP_PRE, ptr, 1'b0);
                     next_active[ptr] = 1'b0;
                     next_trp[ptr] = srf_pkg::RP_CYC;
                  end else if (busy_free && precharge_recovery_time[ptr] == '0 &&
                               t_rrd == '0) begin
                     next_cs_n = 1'b0;
                     next_ca = enc({1'b0, srf_pkg::OP_REF}, '0, 1'b0);
                     next_pb_bank = ptr;
                     next_ptr = ptr + 1'b1;
                     next_t_pb = srf_pkg::RFCPB_CYC;
                     next_ref_d = 1'b1;
                     next_due = 1'b0;
                     if (ptr == BW'(7))
                        next_need_ref = 1'b0;
                  end
               end else begin
                  if (active != '0) begin
                     next_cs_n = 1'b0;
                     next_ca = enc(srf_pkg::OP_PRE, '0, 1'b1);
                     next_active = '0;
                     for (int i = 0; i < 8; i++)
                        next_trp[i] = srf_pkg::RP_CYC;
                  end else if (busy_free && trp_clear &&
                               t_gap == '0) begin
                     next_cs_n = 1'b0;
                     next_ca = enc({1'b1, srf_pkg::OP_REF}, '0, 1'b0);
                     next_ptr = '0;
                     next_t_ab = srf_pkg::RFCAB_CYC;
                     // spacing keeps at most eight in a burst window
                     next_t_gap = srf_pkg::BURST_GAP_CYC;
                     next_ref_d = 1'b1;
                     next_due = 1'b0;
                     next_need_ref = 1'b0;
                  end
               end
            end else if (SR_REQ) begin
               if (active != '0) begin
                  next_cs_n = 1'b0;
                  next_ca = enc(srf_pkg::OP_PRE, '0, 1'b1);
                  next_active = '0;
                  for (int i = 0; i < 8; i++)
                     next_trp[i] = srf_pkg::RP_CYC;
               end else if (busy_free && trp_clear) begin
                  // entered right after a refresh burst at the latest
                  next_cs_n = 1'b0;
                  next_cke = 1'b0;
                  next_ca = enc({1'b1, srf_pkg::OP_REF}, '0, 1'b0);
                  next_st = ST_SREF;
               end
            end else if (PRE_REQ) begin
               next_cs_n = 1'b0;
               next_ca = enc(srf_pkg::OP_PRE, PRE_BANK, PRE_ALL);
               next_pre_d = 1'b1;
               for (int i = 0; i < 8; i++) begin
                  if (PRE_ALL || PRE_BANK == BW'(i)) begin
                     next_active[i] = 1'b0;
                     next_trp[i] = srf_pkg::RP_CYC;
                  end
               end
            end else if (ACT_REQ && !active[ACT_BANK] &&
                         precharge_recovery_time[ACT_BANK] == '0 && t_rrd == '0 &&
                         t_ab == '0 &&
                         !(t_pb != '0 && ACT_BANK == pb_bank)) begin
               next_cs_n = 1'b0;
               next_ca = enc({2'b00, srf_pkg::OP_ACT}, ACT_BANK, 1'b0);
               next_active[ACT_BANK] = 1'b1;
               next_t_rrd = srf_pkg::RRD_CYC;
               next_act_d = 1'b1;
            end
         end
         ST_SREF: begin
            next_cke = 1'b0;
            next_due = 1'b0;
            next_t_refi = srf_pkg::REFI_CYC;
            if (!SR_REQ) begin
               next_cke = 1'b1;
               next_st = ST_XSR;
               next_t_ab = srf_pkg::XSR_CYC;
               next_ptr = '0;
               // require a full refresh round before the next self-refresh entry
               next_need_ref = 1'b1;
            end
         end
         ST_XSR: begin
            if (t_ab == '0)
               next_st = ST_RUN;
         end
         default: next_st = ST_RUN;
      endcase
      // one refresh per interval; after the commands so a new one wins
      if (st == ST_RUN && t_refi == '0) begin
         next_due = 1'b1;
         next_t_refi = USE_PER_BANK ? srf_pkg::REFI_PB_CYC
                                    : srf_pkg::REFI_CYC;
      end
      next_in_sr = next_st != ST_RUN;
   end
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st <= ST_RUN;
         cke <= 1'b1;
         cs_n <= 1'b1;
         ca <= '0;
         ptr <= '0;
         pb_bank <= '0;
         active <= '0;
         t_ab <= '0;
         t_pb <= '0;
         t_rrd <= '0;
         t_gap <= '0;
         t_refi <= srf_pkg::REFI_CYC;
         due <= 1'b0;
         need_ref <= 1'b0;
         act_d <= 1'b0;
         pre_d <= 1'b0;
         ref_d <= 1'b0;
         in_sr <= 1'b0;
         for (int i = 0; i < 8; i++)
            precharge_recovery_time[i] <= '0;
      end else if (CLK_EN) begin
         st <= next_st;
         cke <= next_cke;
         cs_n <= next_cs_n;
         ca <= next_ca;
         ptr <= next_ptr;
         pb_bank <= next_pb_bank;
         active <= next_active;
         t_ab <= next_t_ab;
         t_pb <= next_t_pb;
         t_rrd <= next_t_rrd;
         t_gap <= next_t_gap;
         t_refi <= next_t_refi;
         due <= next_due;
         need_ref <= next_need_ref;
         act_d <= next_act_d;
         pre_d <= next_pre_d;
         ref_d <= next_ref_d;
         in_sr <= next_in_sr;
         for (int i = 0; i < 8; i++)
            precharge_recovery_time[i] <= next_trp[i];
      end
   end
   assign BUS.cke = cke;
   assign BUS.cs_n = cs_n;
   assign BUS.ca = ca;
   assign ACT_DONE = act_d;
   assign PRE_DONE = pre_d;
   assign REF_ISSUED = ref_d;
   assign REF_PTR = ptr;
   assign IN_SELF_REFRESH = in_sr;
endmodule : srf_ctrl

/* test/srf_assertions.sv */
// checker: timing relations on the refresh command bus
`timescale 1ns/1ps
module srf_assertions (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // command bus
   input wire logic cke,
   input wire logic cs_n,
   input wire logic [srf_pkg::CA_W-1:0] ca,
   // device status
   input wire logic [srf_pkg::BANK_W-1:0] REF_PTR,
   input wire logic REF_BANK_PULSE,
   input wire logic REF_ALL_PULSE,
   input wire logic [7:0] BANK_BUSY,
   input wire logic CMD_ERROR
);
   // ----------------------------------------------------------
   // decoded bus words
   // ----------------------------------------------------------
   logic ref_pb;
   logic ref_ab;
   logic act;
   assign ref_pb = CLK_EN && cke && !cs_n && ca[3:0] == 4'h4;
   assign ref_ab = CLK_EN && cke && !cs_n && ca[3:0] == 4'hc;
   assign act = CLK_EN && cke && !cs_n && ca[1:0] == 2'h2;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   a_pb_pulse_follows: assert property (
      ref_pb |=> REF_BANK_PULSE) else $error("pb refresh not taken");
   a_pb_pulse_cause: assert property (
      REF_BANK_PULSE |-> $past(ref_pb)) else $error("pb pulse unprompted");
   a_ab_ptr_clear: assert property (
      ref_ab |=> REF_ALL_PULSE && REF_PTR == 3'h0)
      else $error("ab refresh did not clear pointer");
   a_pb_ptr_step: assert property (
      ref_pb |=> REF_PTR == $past(REF_PTR) + 3'h1)
      else $error("pointer did not advance by one");
   a_pb_bank_busy: assert property (
      ref_pb |=> BANK_BUSY[$past(REF_PTR)])
      else $error("pointed bank not busy");
   a_ab_all_busy: assert property (
      ref_ab |=> BANK_BUSY == 8'hff) else $error("ab not all busy");
   a_pb_gap_kept: assert property (
      ref_pb |=> !(ref_pb || ref_ab)) else $error("pb spacing broken");
   a_ab_gap_kept: assert property (
      ref_ab |=> !(ref_pb || ref_ab || act) [*3])
      else $error("ab spacing broken");
   a_ab_burst_cap: assert property (
      ref_ab |=> !ref_ab [*8]) else $error("ab burst too dense");
   a_no_cmd_error: assert property (
      !CMD_ERROR) else $error("device refused a command");
   a_sr_exit_clear: assert property (
      $rose(cke) |=> REF_PTR == 3'h0) else $error("exit kept pointer");
endmodule : srf_assertions

/* test/sdram_refresh_command_logic_test.sv */
// testbench: controller and memory refresh ends joined on one bus
`timescale 1ns/1ps
module sdram_refresh_command_logic_test;
   logic SYS_CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic use_pb = 1'b1;
   logic act_req = 1'b0;
   logic [2:0] act_bank = 3'h0;
   logic sr_req = 1'b0;
   logic clk_en = 1'b1;
   logic pre_req = 1'b0;
   logic pre_all = 1'b0;
   logic [2:0] pre_bank = 3'h0;
   logic pre_done;
   logic act_done, ref_issued, c_sr, d_pulse, d_all, d_err, d_sr;
   logic b_pulse, b_err, q_pulse, q_err;
   logic [2:0] c_ptr, d_ptr, b_ptr;
   logic [7:0] d_act, d_busy;
   int fails = 0;
   int check_count = 0;
   srf_if bus ();
   srf_if bad_bus ();
   srf_ctrl i_srf_ctrl (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .CLK_EN(clk_en), .BUS(bus.ctrl), .USE_PER_BANK(use_pb),
      .ACT_REQ(act_req), .ACT_BANK(act_bank), .PRE_REQ(pre_req),
      .PRE_ALL(pre_all), .PRE_BANK(pre_bank), .SR_REQ(sr_req),
      .ACT_DONE(act_done), .PRE_DONE(pre_done), .REF_ISSUED(ref_issued),
      .REF_PTR(c_ptr), .IN_SELF_REFRESH(c_sr));
   srf_device i_srf_device (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .CLK_EN(clk_en), .BUS(bus.dev), .REF_PTR(d_ptr),
      .REF_BANK_PULSE(d_pulse), .REF_ALL_PULSE(d_all),
      .BANK_ACTIVE(d_act), .BANK_BUSY(d_busy), .IN_SELF_REFRESH(d_sr),
      .CMD_ERROR(d_err));
   // second bus: the bench breaks timing rules on purpose here
   srf_device i_srf_device_b (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .CLK_EN(clk_en), .BUS(bad_bus.dev), .REF_PTR(b_ptr),
      .REF_BANK_PULSE(b_pulse), .REF_ALL_PULSE(), .BANK_ACTIVE(),
      .BANK_BUSY(), .IN_SELF_REFRESH(), .CMD_ERROR(b_err));
   srf_device #(.NUM_BANKS(4)) i_srf_device_q (.SYS_CLK(SYS_CLK),
      .RESET_N(RESET_N), .CLK_EN(clk_en), .BUS(bad_bus.dev), .REF_PTR(),
      .REF_BANK_PULSE(q_pulse), .REF_ALL_PULSE(), .BANK_ACTIVE(),
      .BANK_BUSY(), .IN_SELF_REFRESH(), .CMD_ERROR(q_err));
   srf_assertions i_srf_assertions (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .CLK_EN(clk_en), .cke(bus.cke), .cs_n(bus.cs_n), .ca(bus.ca),
      .REF_PTR(d_ptr), .REF_BANK_PULSE(d_pulse), .REF_ALL_PULSE(d_all),
      .BANK_BUSY(d_busy), .CMD_ERROR(d_err));
   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic check(input string what, input logic [9:0] seen,
         input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   function automatic logic pick(input int sel);
      case (sel)
         0: return ref_issued;
         1: return act_done;
         2: return d_sr;
         3: return pre_done;
         default: return c_sr;
      endcase
   endfunction : pick
   // bounded wait; refresh intervals are 195 cycles at most
   task automatic wait_on(input int sel, input logic lvl);
      int n;
      n = 0;
      @(posedge SYS_CLK);
      #1;
      while (pick(sel) !== lvl && n < 400) begin
         @(posedge SYS_CLK);
         #1;
         n++;
      end
      check("wait", {9'h0, pick(sel)}, {9'h0, lvl});
   endtask : wait_on
   task automatic step(input logic cs, input logic [9:0] word);
      @(posedge SYS_CLK);
      bad_bus.cs_n <= cs;
      bad_bus.ca <= word;
   endtask : step
   // ----------------------------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------------------------
   initial begin
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      #(40 * 4000);
      fails++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      tally_and_finish();
   end
   initial begin
      bad_bus.cke <= 1'b1;
      bad_bus.cs_n <= 1'b1;
      bad_bus.ca <= 10'h000;
      repeat (4) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      #1;
      check("reset ptr", {4'h0, c_ptr, d_ptr}, 10'h000);
      for (int k = 1; k <= 9; k++) begin
         wait_on(0, 1'b1);
         check("pb word", bus.ca, 10'h004);
         check("ctrl ptr", {7'h0, c_ptr}, 10'(k % 8));
         @(posedge SYS_CLK);
         #1;
         check("dev ptr", {6'h0, d_pulse, d_ptr}, 10'h8 | 10'(k % 8));
      end
      $display("test pb walk done");
      use_pb <= 1'b0;
      act_bank <= 3'h5;
      act_req <= 1'b1;
      wait_on(1, 1'b1);
      act_req <= 1'b0;
      @(posedge SYS_CLK);
      #1;
      check("open bank", {2'h0, d_act}, 10'h020);
      wait_on(0, 1'b1);
      check("ab word", bus.ca, 10'h00c);
      check("ctrl ptr ab", {7'h0, c_ptr}, 10'h000);
      @(posedge SYS_CLK);
      #1;
      check("ab ptr", {6'h0, d_all, d_ptr}, 10'h008);
      check("ab active", {2'h0, d_act}, 10'h000);
      check("ab busy", {2'h0, d_busy}, 10'h0ff);
      // frozen mid all-bank refresh, so the pulse and busy bits hold their values
      clk_en <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      #1;
      check("freeze", {1'b0, d_all, d_busy}, 10'h1ff);
      clk_en <= 1'b1;
      $display("test ab refresh done");
      use_pb <= 1'b1;
      wait_on(0, 1'b1);
      sr_req <= 1'b1;
      wait_on(2, 1'b1);
      check("sr cke", {8'h0, bus.cke, d_ptr == 3'h0}, 10'h000);
      sr_req <= 1'b0;
      wait_on(2, 1'b0);
      check("exit ptr", {4'h0, c_ptr, d_ptr}, 10'h000);
      check("xsr wait", {9'h0, c_sr}, 10'h001);
      wait_on(4, 1'b0);
      pre_bank <= 3'h3;
      pre_req <= 1'b1;
      wait_on(3, 1'b1);
      pre_req <= 1'b0;
      check("pre word", bus.ca, 10'h18b);
      $display("test self refresh exit done");
      step(1'b0, 10'h004);
      // open the bank just refreshed: it must be refused
      step(1'b0, 10'h002);
      #1;
      check("pb taken", {6'h0, b_pulse, b_ptr}, 10'h009);
      check("pb four banks", {8'h0, q_pulse, q_err}, 10'h001);
      step(1'b1, 10'h000);
      #1;
      check("pb busy", {6'h0, b_err, b_ptr}, 10'h009);
      repeat (3) step(1'b1, 10'h000);
      step(1'b0, 10'h004);
      step(1'b0, 10'h3f0);
      #1;
      check("ptr two", {7'h0, b_ptr}, 10'h002);
      step(1'b1, 10'h000);
      #1;
      check("reset cmd", {7'h0, b_ptr}, 10'h000);
      $display("test rule breaking bus done");
      tally_and_finish();
   end
endmodule : sdram_refresh_command_logic_test
